// ===== dcr_duty_cycle_readback.sv
// dcr_duty_cycle_readback: serial duty cycle readback for four channels.
// assumes a plain register port on core_clk and a serial host on sclk.
`timescale 1ns/1ps
module dcr_duty_cycle_readback
  import dcr_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [dcr_pkg::DCR_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic [dcr_pkg::DCR_CHANNELS-1:0] pwm_out
);
  import dcr_pkg::*;

  logic [DCR_PERIOD_W-1:0] period_ff, nxt_period;
  logic [DCR_DUTY_W-1:0] setpt_ff [DCR_CHANNELS];
  logic [DCR_DUTY_W-1:0] nxt_setpt [DCR_CHANNELS];
  logic [DCR_DUTY_W-1:0] duty_meas [DCR_CHANNELS];
  logic [31:0] rdata_ff, nxt_rdata;
  logic [31:0] resp_ff, nxt_resp;
  logic [31:0] lastreq_ff, nxt_lastreq;
  logic [2:0] tgl_sync_ff, nxt_tgl_sync;
  logic [31:0] link_req;
  logic link_tgl;
  logic req_new;
  logic [1:0] req_ch;

  dcr_spi_link u_link (
    .sclk(sclk),
    .nrst(nrst),
    .cs_n(cs_n),
    .mosi(mosi),
    .resp_word(resp_ff),
    .miso_ff(miso),
    .req_ff(link_req),
    .req_tgl_ff(link_tgl)
  );

  for (genvar g = 0; g < DCR_CHANNELS; g++)
  begin : g_chan
    dcr_pwm_chan u_chan (
      .core_clk(core_clk),
      .nrst(nrst),
      .period_n(period_ff),
      .setpoint(setpt_ff[g]),
      .pwm_ff(pwm_out[g]),
      .duty_ff(duty_meas[g])
    );
  end

  // request event crossing: two stages sync the toggle, third finds edge;
  // the request word is stable well before the toggle is seen
  always_comb
  begin
    nxt_tgl_sync = {tgl_sync_ff[1:0], link_tgl};
    req_new = tgl_sync_ff[2] ^ tgl_sync_ff[1];
    req_ch = link_req[DCR_CH_HI:DCR_CH_LO];
  end

  // answer builder
  always_comb
  begin
    nxt_resp = resp_ff;
    nxt_lastreq = lastreq_ff;
    if (req_new)
    begin
      nxt_lastreq = link_req;
      nxt_resp = DCR_RESP_RST;
      // bit 31 of the request is never looked at
      if (link_req[DCR_ID_HI:DCR_ID_LO] == DCR_ID_DUTY_READ)
      begin
        nxt_resp[DCR_ID_HI:DCR_ID_LO] = DCR_ID_DUTY_READ;
        nxt_resp[DCR_CH_HI:DCR_CH_LO] = req_ch;
        nxt_resp[DCR_DUTY_HI:DCR_DUTY_LO] = duty_meas[req_ch];
      end
      // bit 31 and bits 23:19 stay zero; shifted out next frame
    end
  end

  // register port
  always_comb
  begin
    nxt_period = period_ff;
    for (int i = 0; i < DCR_CHANNELS; i++)
    begin
      nxt_setpt[i] = setpt_ff[i];
    end
    nxt_rdata = '0;
    if (reg_wr)
    begin
      if (reg_addr == DCR_REG_PERIOD)
      begin
        nxt_period = reg_wdata[DCR_PERIOD_W-1:0];
      end
      for (int i = 0; i < DCR_CHANNELS; i++)
      begin
        if (reg_addr == DCR_REG_SETPT0 + DCR_ADDR_W'(i) * DCR_REG_STRIDE)
        begin
          // held here; the channel adopts it at its own period start
          nxt_setpt[i] = reg_wdata[DCR_DUTY_W-1:0];
        end
      end
    end
    if (reg_rd)
    begin
      if (reg_addr == DCR_REG_PERIOD)
      begin
        nxt_rdata = {{(32-DCR_PERIOD_W){1'b0}}, period_ff};
      end
      if (reg_addr == DCR_REG_LASTREQ)
      begin
        nxt_rdata = lastreq_ff;
      end
      for (int i = 0; i < DCR_CHANNELS; i++)
      begin
        if (reg_addr == DCR_REG_SETPT0 + DCR_ADDR_W'(i) * DCR_REG_STRIDE)
        begin
          nxt_rdata = {{(32-DCR_DUTY_W){1'b0}}, setpt_ff[i]};
        end
        if (reg_addr == DCR_REG_DUTY0 + DCR_ADDR_W'(i) * DCR_REG_STRIDE)
        begin
          nxt_rdata = {{(32-DCR_DUTY_W){1'b0}}, duty_meas[i]};
        end
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      period_ff <= DCR_PERIOD_RST;
      for (int i = 0; i < DCR_CHANNELS; i++)
      begin
        setpt_ff[i] <= DCR_SETPT_RST;
      end
      rdata_ff <= '0;
      resp_ff <= DCR_RESP_RST;
      lastreq_ff <= '0;
      tgl_sync_ff <= '0;
    end
    else
    begin
      period_ff <= nxt_period;
      for (int i = 0; i < DCR_CHANNELS; i++)
      begin
        setpt_ff[i] <= nxt_setpt[i];
      end
      rdata_ff <= nxt_rdata;
      resp_ff <= nxt_resp;
      lastreq_ff <= nxt_lastreq;
      tgl_sync_ff <= nxt_tgl_sync;
    end
  end

  assign reg_rdata = rdata_ff;
endmodule // dcr_duty_cycle_readback

// ===== dcr_duty_cycle_readback_checker.sv
// dcr_duty_cycle_readback_checker: port assertions on core_clk.
// assumes it is bound to the readback top module.
`timescale 1ns/1ps
module dcr_duty_cycle_readback_checker
  import dcr_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [dcr_pkg::DCR_ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic cs_n,
  input wire logic miso,
  input wire logic [dcr_pkg::DCR_CHANNELS-1:0] pwm_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data without a read");
  a_duty_upper: assert property ($past(reg_rd) && $past(reg_addr) inside
    {8'h14, 8'h18, 8'h1c, 8'h20} |-> reg_rdata[31:19] == 13'h0)
    else $error("duty read has high bits set");
  a_unmapped_zero: assert property ($past(reg_rd) &&
    $past(reg_addr) > DCR_REG_LASTREQ |-> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_miso_idle: assert property (cs_n && $past(cs_n) |-> !miso)
    else $error("miso high outside frame");
  a_miso_lead: assert property ($fell(cs_n) |-> !miso)
    else $error("first answer bit not zero");
  a_pwm_rst: assert property ($rose(nrst) |-> pwm_out == '0)
    else $error("pwm active at reset release");
endmodule // dcr_duty_cycle_readback_checker

// ===== dcr_host.sv
// dcr_host: behavioural serial host framing 32-bit requests.
// assumes the device answers a request in the following frame.
`timescale 1ns/1ps
module dcr_host
(
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b0;
    mosi = 1'b0;
    // a sure rising select clears the link's frame position at start
    #1 cs_n = 1'b1;
  end
  // clock stands still between frames; the long tail lets the core settle
  task xfer(input logic [31:0] req, output logic [31:0] rsp);
    #7 cs_n = 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      mosi = req[i];
      #16 rsp[i] = miso;
      sclk = 1'b1;
      #16 sclk = 1'b0;
    end
    #16 cs_n = 1'b1;
    mosi = ~mosi;  // released line must not show a stale bit
    #130;
  endtask
endmodule // dcr_host

// ===== dcr_pkg.sv
// dcr_pkg: constants shared by the duty cycle readback block.
// assumes a 32-bit serial frame, msb first, and a 100 MHz core clock.
package dcr_pkg;
  localparam int unsigned DCR_CHANNELS = 4;
  localparam int unsigned DCR_FRAME_BITS = 32;
  localparam int unsigned DCR_DUTY_W = 19;
  localparam int unsigned DCR_PERIOD_W = 14;
  localparam int unsigned DCR_SCALE_SHIFT = 5;  // duty count scale of 32
  localparam int unsigned DCR_ADDR_W = 8;
  // frame field positions
  localparam int unsigned DCR_RW_BIT = 31;
  localparam int unsigned DCR_ID_HI = 30;
  localparam int unsigned DCR_ID_LO = 26;
  localparam int unsigned DCR_CH_HI = 25;
  localparam int unsigned DCR_CH_LO = 24;
  localparam int unsigned DCR_DUTY_HI = 18;
  localparam int unsigned DCR_DUTY_LO = 0;
  localparam logic [4:0] DCR_ID_DUTY_READ = 5'h0c;
  localparam logic [4:0] DCR_BITCNT_LAST = 5'h1f;
  // register map (byte addresses)
  localparam logic [7:0] DCR_REG_PERIOD = 8'h00;
  localparam logic [7:0] DCR_REG_SETPT0 = 8'h04;
  localparam logic [7:0] DCR_REG_DUTY0 = 8'h14;
  localparam logic [7:0] DCR_REG_LASTREQ = 8'h24;
  localparam logic [7:0] DCR_REG_STRIDE = 8'h04;
  // reset values
  localparam logic [13:0] DCR_PERIOD_RST = 14'h0001;
  localparam logic [18:0] DCR_SETPT_RST = 19'h00000;
  localparam logic [31:0] DCR_RESP_RST = 32'h00000000;
endpackage : dcr_pkg

// ===== dcr_pwm_chan.sv
// dcr_pwm_chan: one pwm output channel with duty measurement.
// assumes period_n and setpoint are quasi-static core_clk registers.
`timescale 1ns/1ps
module dcr_pwm_chan
  import dcr_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [DCR_PERIOD_W-1:0] period_n,
  input wire logic [DCR_DUTY_W-1:0] setpoint,
  output logic pwm_ff,
  output logic [DCR_DUTY_W-1:0] duty_ff
);
  logic [DCR_DUTY_W-1:0] cnt_ff, nxt_cnt;
  logic [DCR_DUTY_W-1:0] active_sp_ff, nxt_active_sp;
  logic [DCR_DUTY_W-1:0] high_ff, nxt_high;
  logic [DCR_DUTY_W-1:0] nxt_duty;
  logic nxt_pwm;
  logic [DCR_PERIOD_W-1:0] n_eff;
  logic [DCR_DUTY_W-1:0] cnt_last;

  always_comb
  begin
    // a period setting of zero would give no cycle at all; run as one
    n_eff = (period_n == '0) ? DCR_PERIOD_RST : period_n;
    cnt_last = DCR_DUTY_W'({n_eff, {DCR_SCALE_SHIFT{1'b0}}} - 1);
    nxt_cnt = (cnt_ff >= cnt_last) ? '0 : cnt_ff + 1'b1;
    nxt_active_sp = active_sp_ff;
    nxt_high = high_ff + DCR_DUTY_W'(pwm_ff);
    nxt_duty = duty_ff;
    if (cnt_ff >= cnt_last)
    begin
      // new setpoint taken at the next pwm cycle start
      nxt_active_sp = setpoint;
      // high ticks per 32*N period, scaled as the reported count
      nxt_duty = high_ff + DCR_DUTY_W'(pwm_ff);
      nxt_high = '0;
    end
    nxt_pwm = (nxt_cnt < nxt_active_sp);
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      cnt_ff <= '0;
      active_sp_ff <= DCR_SETPT_RST;
      high_ff <= '0;
      duty_ff <= '0;
      pwm_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      active_sp_ff <= nxt_active_sp;
      high_ff <= nxt_high;
      duty_ff <= nxt_duty;
      pwm_ff <= nxt_pwm;
    end
  end
endmodule // dcr_pwm_chan

// ===== dcr_spi_link.sv
// dcr_spi_link: 32-bit frame shifter on the serial link clock.
// assumes the host frames with cs_n, stops sclk between frames, and
// leaves at least 100 ns between frames so resp_word has settled;
// nrst is asserted and released only while sclk stands still.
`timescale 1ns/1ps
module dcr_spi_link
  import dcr_pkg::*;
(
  input wire logic sclk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic [31:0] resp_word,
  output logic miso_ff,
  output logic [31:0] req_ff,
  output logic req_tgl_ff
);
  logic [4:0] bitcnt_ff, nxt_bitcnt;
  logic [31:0] sin_ff, nxt_sin;
  logic [30:0] sout_ff, nxt_sout;
  logic nxt_miso, nxt_tgl;
  logic [31:0] nxt_req;

  always_comb
  begin
    nxt_bitcnt = bitcnt_ff + 5'h01;
    nxt_sin = {sin_ff[30:0], mosi};
    nxt_sout = {sout_ff[29:0], 1'b0};
    nxt_miso = sout_ff[30];
    nxt_req = req_ff;
    nxt_tgl = req_tgl_ff;
    if (bitcnt_ff == '0)
    begin
      // resp_word settles early in the gap and is held through the frame; bit 31 of
      // every answer is zero so it needs no load before the first edge
      nxt_sout = {resp_word[29:0], 1'b0};
      nxt_miso = resp_word[30];
    end
    if (bitcnt_ff == DCR_BITCNT_LAST)
    begin
      nxt_req = {sin_ff[30:0], mosi};
      nxt_tgl = ~req_tgl_ff;
    end
  end

  // frame position restarts whenever the host deselects
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      bitcnt_ff <= '0;
      miso_ff <= 1'b0;
    end
    else
    begin
      bitcnt_ff <= nxt_bitcnt;
      miso_ff <= nxt_miso;
    end
  end

  // an unreset toggle would stay unknown for ever and the core could
  // never see a request; sclk is idle around nrst, so its asynchronous
  // release cannot meet a link clock edge
  always_ff @(posedge sclk or negedge nrst)
  begin
    if (!nrst)
    begin
      req_ff <= '0;
      req_tgl_ff <= 1'b0;
    end
    else if (!cs_n)
    begin
      req_ff <= nxt_req;
      req_tgl_ff <= nxt_tgl;
    end
  end

  always_ff @(posedge sclk)
  begin
    if (!cs_n)
    begin
      sin_ff <= nxt_sin;
      sout_ff <= nxt_sout;
    end
  end
endmodule // dcr_spi_link

// ===== test_duty_cycle_readback.sv
// test_duty_cycle_readback: self-checking bench for the readback block.
// assumes the dcr_host serial model and the bound port checker.
`timescale 1ns/1ps
module test_duty_cycle_readback;
  import dcr_pkg::*;
  logic core_clk = 0;
  logic nrst;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [31:0] reg_rdata, rsp;
  logic sclk, cs_n, mosi, miso;
  logic [3:0] pwm_out;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  int seed = 32'hc7823b8a;
  int sp [4];
  int pc [4];
  logic [31:0] exp_q [$];
  always #5 core_clk = ~core_clk;
  dcr_duty_cycle_readback uut(.core_clk(core_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .miso(miso), .pwm_out(pwm_out));
  dcr_host host(.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    check_count++;
    if (seen !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, seen);
      fail_count++;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      conclude;
    end
  end
  initial
  begin
    logic [31:0] d;
    logic [31:0] q;
    // driven, not initialised, so the link's asynchronous reset sees it
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    wr(DCR_REG_PERIOD, 32'h2);
    rd(DCR_REG_PERIOD, d);
    chk("period", d, 32'h2);
    // unknown id flushes the unreset link start; its answer is all zeros
    host.xfer(32'h0, rsp);
    exp_q.push_back(32'h0);
    repeat (2)
    begin
      for (int c = 0; c < 4; c++)
      begin
        sp[c] = $unsigned($random(seed)) % 65;
        wr(DCR_REG_SETPT0 + 8'(4 * c), 32'(sp[c]));
      end
      // one period to apply the setpoint, then count each output over
      // one full period of 32*N = 64 ticks
      repeat (76) @(posedge core_clk);
      for (int c = 0; c < 4; c++)
        pc[c] = 0;
      repeat (64)
      begin
        @(posedge core_clk);
        #1;
        for (int c = 0; c < 4; c++)
          pc[c] += pwm_out[c];
      end
      for (int c = 0; c < 4; c++)
        chk("pwm high ticks", 32'(pc[c]), 32'(sp[c]));
      for (int c = 0; c < 4; c++)
      begin
        rd(DCR_REG_DUTY0 + 8'(4 * c), d);
        chk("duty", d, 32'(sp[c]));
      end
      rd(8'h80, d);
      chk("unmapped", d, 32'h0);
      for (int c = 0; c < 5; c++)
      begin
        if (c < 4)
          exp_q.push_back({1'b0, 5'h0c, 2'(c), 5'h0, 19'(sp[c])});
        else
          exp_q.push_back(32'h0);
        q = c < 4 ? {1'($random(seed)), 5'h0c, 2'(c), 24'h0}
          : {1'b0, 5'h0a, 26'h0};
        host.xfer(q, rsp);
        chk("answer", rsp, exp_q.pop_front());
        rd(DCR_REG_LASTREQ, d);
        chk("last request", d, q);
      end
      $display("round done");
    end
    conclude;
  end
endmodule // test_duty_cycle_readback

bind dcr_duty_cycle_readback dcr_duty_cycle_readback_checker u_chk(
  .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .cs_n(cs_n), .miso(miso), .pwm_out(pwm_out));
